/* File: dsw_bank_if.sv */
// link between command decode and the bank state tracker
`timescale 1ns/1ps
`default_nettype none

interface dsw_bank_if;
    logic       ck_rise;
    logic       act_req;
    logic [2:0] act_bank;
    logic       pre_req;
    logic       pre_all;
    logic [2:0] pre_bank;
    logic       ap_req;
    logic [2:0] ap_bank;
    logic [3:0] trp;
    logic [7:0] bank_open;
    logic [7:0] bank_pre;

    modport ctl (output ck_rise, act_req, act_bank, pre_req, pre_all,
                 output pre_bank, ap_req, ap_bank, trp,
                 input bank_open, bank_pre);
    modport bnk (input ck_rise, act_req, act_bank, pre_req, pre_all,
                 input pre_bank, ap_req, ap_bank, trp,
                 output bank_open, bank_pre);
endinterface

`default_nettype wire

/* File: dsw_banks.sv */
// per-bank open and precharge tracking
`timescale 1ns/1ps
`default_nettype none
`include "dsw_defs.svh"

module dsw_banks (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    dsw_bank_if.bnk   bi
);
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bank
            logic [3:0] cnt_r;
            logic       hit_pre;
            logic       hit_act;
            assign hit_pre = (bi.pre_req &&
                              (bi.pre_all || bi.pre_bank == 3'(i))) ||
                             (bi.ap_req && bi.ap_bank == 3'(i));
            assign hit_act = bi.act_req && bi.act_bank == 3'(i);
            // restart period
            // a later precharge reloads the timer
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    cnt_r           <= 4'h0;
                    bi.bank_open[i] <= 1'b0;
                    bi.bank_pre[i]  <= 1'b0;
                end else if (ce) begin
                    if (hit_pre) begin
                        cnt_r           <= bi.trp;
                        bi.bank_open[i] <= 1'b0;
                        bi.bank_pre[i]  <= (bi.trp != 4'h0);
                    end else if (hit_act) begin
                        bi.bank_open[i] <= 1'b1;
                    end else if (bi.ck_rise && cnt_r != 4'h0) begin
                        cnt_r          <= cnt_r - 4'h1;
                        bi.bank_pre[i] <= (cnt_r != 4'h1);
                    end
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

/* File: dsw_ctl_model.sv */
// controller model driving command, strobe and data pins
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------
// controller model
// ----------------------------------------------------------
module dsw_ctl_model (
    output var logic        ck,
    output var logic        cs_b,
    output var logic        ras_b,
    output var logic        cas_b,
    output var logic        we_b,
    output var logic [2:0]  ba,
    output var logic [13:0] addr,
    output var logic        dqs,
    output var logic [7:0]  dq,
    output var logic        dm
);
    logic [63:0] dat[2];
    logic [7:0]  msk[2];

    // idle pins, then a free running 160 ns link clock
    initial begin
        {cs_b, ras_b, cas_b, we_b, ba, addr, dqs, dq, dm} = '1;
        ck = 1'b0;
    end
    always #80 ck = ~ck;

    task automatic cmd(input logic [2:0] rcw, input logic [2:0] b,
                       input logic [13:0] a);
        @(negedge ck);
        {cs_b, ras_b, cas_b, we_b, ba, addr} = {1'b0, rcw, b, a};
        @(negedge ck);
        {cs_b, ras_b, cas_b, we_b, ba, addr} = {4'hf, ~b, ~a};
    endtask

    // n writes four clocks apart with one continuous strobe
    task automatic wr(input int n, input int wl, input int nb,
                      input logic [2:0] b, input logic [9:0] c,
                      input logic ap, input logic a12);
        fork
            for (int k = 0; k < n; k++) begin
                cmd(3'b100, b, {1'b0, a12, 1'b0, ap, c});
                repeat (2) @(negedge ck);
            end
            begin
                @(negedge ck);
                @(posedge ck);
                repeat (wl - 1) @(posedge ck);
                dqs = 1'b1;
                @(negedge ck);
                dqs = 1'b0;
                for (int i = 0; i < n * nb; i++) begin
                    #40 dq = dat[i / nb][8 * (i % nb) +: 8];
                    dm = msk[i / nb][i % nb];
                    #40 dqs = ~dqs;
                end
                #80 dqs = 1'b1;
                dq = ~dq;
                dm = ~dm;
            end
        join
    endtask

    task automatic junk();
        repeat (4) begin
            #80 dqs = ~dqs;
            dq = ~dq;
        end
    endtask
endmodule

`default_nettype wire

/* File: dsw_defs.svh */
// constants for the write and precharge path of the memory device
`ifndef DSW_DEFS_SVH
`define DSW_DEFS_SVH

// register offsets (byte addresses)
`define DSW_REG_MODE   8'h00
`define DSW_REG_TIME   8'h04
`define DSW_REG_STAT   8'h08
`define DSW_REG_LAST   8'h0c

// mode register fields, then the timing register field
`define DSW_BL_LSB     0
`define DSW_BL_MSB     1
`define DSW_AL_LSB     4
`define DSW_AL_MSB     8
`define DSW_CWL_LSB    12
`define DSW_CWL_MSB    15
`define DSW_TRP_LSB    0
`define DSW_TRP_MSB    3

// reset values
`define DSW_MODE_RST   32'h0000_5000
`define DSW_TRP_RST    4'h4

// burst length codes
`define DSW_BL_FIX8    2'b00
`define DSW_BL_OTF     2'b01
`define DSW_BL_FIX4    2'b10

// command address bits
`define DSW_A_AP       10
`define DSW_A_BL       12

// burst shape, in beats and in half clocks of the link clock
`define DSW_BEAT_LAST8 3'h7
`define DSW_BEAT_LAST4 3'h3
`define DSW_HALF_BL8   9'h008
`define DSW_HALF_BC4   9'h004
`define DSW_MASK_ALL   8'hff

`endif

/* File: dsw_pkg.sv */
// types shared by the write and precharge path modules
package dsw_pkg;

    typedef enum logic [1:0] {
        dsw_st_idle  = 2'b00,
        dsw_st_burst = 2'b01
    } dsw_state_t;

    typedef struct packed {
        logic [8:0] due;
        logic [2:0] bank;
        logic [9:0] col;
        logic       b8;
        logic       otf;
        logic       ap;
    } dsw_wr_t;

endpackage

/* File: dsw_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module dsw_sync #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_r;
            // first stage feeds only the second
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    meta_r  <= 1'b0;
                    q[i]    <= 1'b0;
                end else if (ce) begin
                    meta_r  <= d[i];
                    q[i]    <= meta_r;
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

/* File: dsw_top.sv */
// write burst capture and precharge handling of the memory device
`timescale 1ns/1ps
`default_nettype none
`include "dsw_defs.svh"

module dsw_top
    import dsw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        ck,
    input  wire logic        cs_b,
    input  wire logic        ras_b,
    input  wire logic        cas_b,
    input  wire logic        we_b,
    input  wire logic [2:0]  ba,
    input  wire logic [13:0] addr,
    input  wire logic        dqs,
    input  wire logic [7:0]  dq_in,
    input  wire logic        dm,
    output logic      [7:0]  dq_out,
    output logic             dq_oe_b,
    output logic             wr_valid,
    output logic      [2:0]  wr_bank,
    output logic      [9:0]  wr_col,
    output logic      [63:0] wr_data,
    output logic      [7:0]  wr_mask,
    output logic             wr_beats8,
    output logic             burst_end,
    output logic      [7:0]  bank_open,
    output logic      [7:0]  bank_pre
);
    // ------------------------------------------------
    // pin synchronisation and edge detection
    // ------------------------------------------------
    logic [31:0] pin_s;
    logic        ck_s;
    logic        dqs_s;
    logic        cs_b_s;
    logic        ras_b_s;
    logic        cas_b_s;
    logic        we_b_s;
    logic [2:0]  ba_s;
    logic [13:0] a_s;
    logic [7:0]  dq_s;
    logic        dm_s;
    logic        ck_d_r;
    logic        dqs_d_r;
    logic        ck_rise;
    logic        ck_fall;
    logic        dqs_rise;
    logic        dqs_edge;

    dsw_sync #(.W(32)) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .d     ({dm, dq_in, dqs, addr, ba, we_b, cas_b, ras_b,
                 cs_b, ck}),
        .q     (pin_s)
    );

    assign {dm_s, dq_s, dqs_s, a_s, ba_s, we_b_s, cas_b_s, ras_b_s,
            cs_b_s, ck_s} = pin_s;

    // previous levels for edge finding
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ck_d_r  <= 1'b0;
            dqs_d_r <= 1'b0;
        end else if (ce) begin
            ck_d_r  <= ck_s;
            dqs_d_r <= dqs_s;
        end
    end

    assign ck_rise  = ck_s & ~ck_d_r;
    assign ck_fall  = ~ck_s & ck_d_r;
    assign dqs_edge = dqs_s ^ dqs_d_r;
    assign dqs_rise = dqs_s & ~dqs_d_r;

    // half-clock counter of the link clock
    logic [8:0] half_r;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            half_r <= 9'h000;
        end else if (ce && (ck_rise || ck_fall)) begin
            half_r <= half_r + 9'h001;
        end
    end

    // ------------------------------------------------
    // registers
    // ------------------------------------------------
    logic [31:0] mode_r;
    logic [3:0]  trp_r;
    logic [1:0]  bl_code;
    logic [4:0]  al;
    logic [3:0]  cwl;
    logic [5:0]  wl;

    assign bl_code = mode_r[`DSW_BL_MSB:`DSW_BL_LSB];
    assign al      = mode_r[`DSW_AL_MSB:`DSW_AL_LSB];
    assign cwl     = mode_r[`DSW_CWL_MSB:`DSW_CWL_LSB];
    assign wl      = {1'b0, al} + {2'b00, cwl};

    // software writes
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode_r <= `DSW_MODE_RST;
            trp_r  <= `DSW_TRP_RST;
        end else if (ce && reg_wr) begin
            if (reg_addr == `DSW_REG_MODE) begin
                mode_r <= reg_wdata;
            end else if (reg_addr == `DSW_REG_TIME) begin
                trp_r <= reg_wdata[`DSW_TRP_MSB:`DSW_TRP_LSB];
            end
        end
    end

    // ------------------------------------------------
    // command decode
    // ------------------------------------------------
    logic cmd_ok;
    logic cmd_wr;
    logic cmd_pre;
    logic cmd_act;

    assign cmd_ok  = ck_rise && !cs_b_s;
    assign cmd_wr  = cmd_ok && ras_b_s && !cas_b_s && !we_b_s;
    assign cmd_pre = cmd_ok && !ras_b_s && cas_b_s && !we_b_s;
    assign cmd_act = cmd_ok && !ras_b_s && cas_b_s && we_b_s;

    dsw_wr_t new_wr;
    always_comb begin
        new_wr      = '0;
        new_wr.due  = half_r + 9'h001 + {2'b00, wl, 1'b0};
        new_wr.bank = ba_s;
        new_wr.col  = a_s[9:0];
        new_wr.otf  = (bl_code == `DSW_BL_OTF) && !a_s[`DSW_A_BL];
        new_wr.b8   = (bl_code != `DSW_BL_FIX4) && !new_wr.otf;
        new_wr.ap   = a_s[`DSW_A_AP];
    end

    // ------------------------------------------------
    // pending write queue
    // ------------------------------------------------
    dsw_wr_t    q_mem [4];
    logic [2:0] wptr_r;
    logic [2:0] rptr_r;
    logic       q_full;
    logic       q_empty;
    logic       pop;
    dsw_wr_t    head;
    logic [8:0] diff;
    logic       start_ok;
    logic       stale;

    assign q_full   = (wptr_r ^ rptr_r) == 3'b100;
    assign q_empty  = wptr_r == rptr_r;
    assign head     = q_mem[rptr_r[1:0]];
    assign diff     = head.due - half_r;
    // first rise lands at write latency
    assign start_ok = (diff == 9'h000) || (diff == 9'h001);
    assign stale    = diff[8];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wptr_r <= 3'h0;
        end else if (ce && cmd_wr && !q_full) begin
            q_mem[wptr_r[1:0]] <= new_wr;
            wptr_r             <= wptr_r + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rptr_r <= 3'h0;
        end else if (ce && pop) begin
            rptr_r <= rptr_r + 3'h1;
        end
    end

    // ------------------------------------------------
    // burst capture
    // ------------------------------------------------
    dsw_state_t state_r;
    logic [2:0] beat_r;
    logic [2:0] beat_last;
    logic [63:0] data_r;
    logic [7:0]  mask_r;
    logic        last_cap;

    assign beat_last = head.b8 ? `DSW_BEAT_LAST8 : `DSW_BEAT_LAST4;
    assign last_cap  = (state_r == dsw_st_burst) && dqs_edge &&
                       (beat_r == beat_last);
    // missed or finished bursts drop out
    assign pop = !q_empty && (last_cap ||
                 ((state_r == dsw_st_idle) && stale));

    // burst sequencing
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= dsw_st_idle;
            beat_r  <= 3'h0;
        end else if (ce) begin
            case (state_r)
                dsw_st_idle: begin
                    if (!q_empty && dqs_rise && start_ok) begin
                        state_r <= dsw_st_burst;
                        beat_r  <= 3'h1;
                    end
                end
                dsw_st_burst: begin
                    // next burst may start at once
                    if (last_cap) begin
                        state_r <= dsw_st_idle;
                        beat_r  <= 3'h0;
                    end else if (dqs_edge) begin
                        beat_r <= beat_r + 3'h1;
                    end
                end
                default: begin
                    state_r <= dsw_st_idle;
                end
            endcase
        end
    end

    // beat capture; unused beats stay masked
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            data_r <= 64'h0;
            mask_r <= `DSW_MASK_ALL;
        end else if (ce) begin
            if (state_r == dsw_st_idle && !q_empty && dqs_rise &&
                start_ok) begin
                data_r        <= {56'h0, dq_s};
                mask_r        <= {`DSW_MASK_ALL} << 1;
                mask_r[0]     <= dm_s;
            end else if (state_r == dsw_st_burst && dqs_edge) begin
                data_r[beat_r*8 +: 8] <= dq_s;
                mask_r[beat_r]        <= dm_s;
            end
        end
    end

    // completed burst out to the array
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_valid  <= 1'b0;
            wr_bank   <= 3'h0;
            wr_col    <= 10'h0;
            wr_data   <= 64'h0;
            wr_mask   <= `DSW_MASK_ALL;
            wr_beats8 <= 1'b0;
        end else if (ce) begin
            wr_valid <= last_cap;
            if (last_cap) begin
                wr_bank               <= head.bank;
                wr_col                <= head.col;
                wr_data               <= data_r;
                wr_data[beat_r*8 +: 8] <= dq_s;
                wr_mask               <= mask_r;
                wr_mask[beat_r]       <= dm_s;
                wr_beats8             <= head.b8;
            end
        end
    end

    // ------------------------------------------------
    // write recovery start and auto precharge
    // ------------------------------------------------
    logic       rec_pend_r;
    logic [8:0] rec_h_r;
    logic [2:0] rec_bank_r;
    logic       rec_ap_r;
    logic       rec_hit;

    assign rec_hit = rec_pend_r && ck_rise &&
                     (rec_h_r - half_r == 9'h001);

    // chop on the fly ends like eight
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rec_pend_r <= 1'b0;
            rec_h_r    <= 9'h000;
            rec_bank_r <= 3'h0;
            rec_ap_r   <= 1'b0;
        end else if (ce) begin
            if (last_cap) begin
                rec_pend_r <= 1'b1;
                rec_h_r    <= head.due + ((head.b8 || head.otf) ?
                              `DSW_HALF_BL8 : `DSW_HALF_BC4);
                rec_bank_r <= head.bank;
                rec_ap_r   <= head.ap;
            end else if (rec_hit) begin
                rec_pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            burst_end <= 1'b0;
        end else if (ce) begin
            burst_end <= rec_hit;
        end
    end

    // ------------------------------------------------
    // bank tracking
    // ------------------------------------------------
    dsw_bank_if bif ();

    assign bif.ck_rise  = ck_rise;
    assign bif.act_req  = cmd_act;
    assign bif.act_bank = ba_s;
    assign bif.pre_req  = cmd_pre;
    assign bif.pre_all  = a_s[`DSW_A_AP];
    assign bif.pre_bank = ba_s;
    assign bif.ap_req   = rec_hit && rec_ap_r;
    assign bif.ap_bank  = rec_bank_r;
    assign bif.trp      = trp_r;

    dsw_banks u_banks (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .bi    (bif.bnk)
    );

    assign bank_open = bif.bank_open;
    assign bank_pre  = bif.bank_pre;

    // ------------------------------------------------
    // data pins and register read back
    // ------------------------------------------------
    // data pins never driven here
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dq_out  <= 8'h00;
            dq_oe_b <= 1'b1;
        end else if (ce) begin
            dq_out  <= 8'h00;
            dq_oe_b <= 1'b1;
        end
    end

    // read data valid only the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0;
        end else if (ce) begin
            if (!reg_rd) begin
                reg_rdata <= 32'h0;
            end else if (reg_addr == `DSW_REG_MODE) begin
                reg_rdata <= mode_r;
            end else if (reg_addr == `DSW_REG_TIME) begin
                reg_rdata <= {28'h0, trp_r};
            end else if (reg_addr == `DSW_REG_STAT) begin
                reg_rdata <= {11'h0, wptr_r - rptr_r, state_r,
                              bif.bank_pre, bif.bank_open};
            end else if (reg_addr == `DSW_REG_LAST) begin
                reg_rdata <= {19'h0, wr_bank, wr_col};
            end else begin
                reg_rdata <= 32'h0;
            end
        end
    end
endmodule

`default_nettype wire

/* File: dsw_top_assertions.sv */
// assertion checker for the write and precharge path
`timescale 1ns/1ps
`default_nettype none
`include "dsw_defs.svh"

// ----------------------------------------------------------
// checker
// ----------------------------------------------------------
module dsw_top_chk
    import dsw_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [7:0]  dq_out,
    input wire logic        dq_oe_b,
    input wire logic        wr_valid,
    input wire logic [2:0]  wr_bank,
    input wire logic [9:0]  wr_col,
    input wire logic [63:0] wr_data,
    input wire logic [7:0]  wr_mask,
    input wire logic        wr_beats8,
    input wire logic        burst_end,
    input wire logic [7:0]  bank_open,
    input wire logic [7:0]  bank_pre
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    oe_high_a: assert property (dq_oe_b)
        else $error("data pins driven");
    dq_zero_a: assert property (dq_out == 8'h00)
        else $error("data output not zero");
    valid_pulse_a: assert property (wr_valid |=> !wr_valid)
        else $error("burst valid longer than one cycle");
    end_pulse_a: assert property (burst_end |=> !burst_end)
        else $error("burst end longer than one cycle");
    end_after_a: assert property (wr_valid |-> ##[4:20] burst_end)
        else $error("no burst end after captured burst");
    fields_hold_a: assert property (1'b1 ##1 !wr_valid |->
        $stable({wr_data, wr_mask, wr_bank, wr_col, wr_beats8}))
        else $error("burst fields changed without valid");
    chop_mask_a: assert property (wr_valid && !wr_beats8
        |-> wr_mask[7:4] == 4'hf)
        else $error("chop burst unused beats not masked");
    bank_excl_a: assert property ((bank_open & bank_pre) == 8'h00)
        else $error("bank open while precharging");
    stat_read_a: assert property (reg_rd && reg_addr == `DSW_REG_STAT
        |=> reg_rdata[15:0] == {$past(bank_pre), $past(bank_open)})
        else $error("status read differs from bank state");
    unmapped_a: assert property (reg_rd && reg_addr > `DSW_REG_LAST
        |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data without read");

    cover property (wr_valid && wr_beats8);
    cover property (wr_valid && !wr_beats8);
    cover property (bank_pre == 8'hff);
endmodule

bind dsw_top dsw_top_chk chk (.clk, .rst_b, .reg_addr, .reg_rd,
    .reg_rdata, .dq_out, .dq_oe_b, .wr_valid, .wr_bank, .wr_col,
    .wr_data, .wr_mask, .wr_beats8, .burst_end, .bank_open, .bank_pre);

`default_nettype wire

/* File: tb_dsw.sv */
// self-checking testbench for the write and precharge path
`timescale 1ns/1ps
`default_nettype none
`include "dsw_defs.svh"

// ----------------------------------------------------------
// testbench
// ----------------------------------------------------------
module testbench;
    logic        clk, rst_b, ce, reg_wr, reg_rd, ck, cs_b, ras_b, cas_b;
    logic        we_b, dqs, dm, dq_oe_b, wr_valid, wr_beats8, burst_end;
    logic [7:0]  reg_addr, dq_in, dq_out, wr_mask, bank_open, bank_pre;
    logic [31:0] reg_wdata, reg_rdata;
    logic [2:0]  ba, wr_bank;
    logic [13:0] addr;
    logic [9:0]  wr_col;
    logic [63:0] wr_data;
    logic [63:0] got_d[$];
    logic [7:0]  got_m[$];
    logic [13:0] got_i[$];
    int          bad_count, n_checks, n_end;
    int          cfg[4][5] = '{'{0, 0, 0, 5, 1}, '{1, 1, 2, 5, 1},
                               '{1, 0, 0, 6, 0}, '{2, 1, 0, 5, 0}};

    dsw_top uut (.clk, .rst_b, .ce, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .ck, .cs_b, .ras_b, .cas_b, .we_b, .ba,
        .addr, .dqs, .dq_in, .dm, .dq_out, .dq_oe_b, .wr_valid, .wr_bank,
        .wr_col, .wr_data, .wr_mask, .wr_beats8, .burst_end, .bank_open,
        .bank_pre);
    dsw_ctl_model ctl (.ck, .cs_b, .ras_b, .cas_b, .we_b, .ba, .addr,
        .dqs, .dq(dq_in), .dm);

    always #10 clk = ~clk;

    // collect captured bursts and burst ends
    always @(posedge clk) begin
        if (wr_valid === 1'b1) begin
            got_d.push_back(wr_data);
            got_m.push_back(wr_mask);
            got_i.push_back({wr_beats8, wr_bank, wr_col});
        end
        if (burst_end === 1'b1) n_end++;
    end

    task check(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task test_done();
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task reg_check(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(64'(reg_rdata), 64'(e));
    endtask

    task t_regs();
        reg_check(`DSW_REG_MODE, `DSW_MODE_RST);
        reg_check(`DSW_REG_TIME, 32'(`DSW_TRP_RST));
        reg_write(`DSW_REG_STAT, 32'hffff_ffff);
        reg_check(`DSW_REG_STAT, 32'h0);
        reg_check(8'h20, 32'h0);
        reg_write(`DSW_REG_TIME, 32'h3);
        reg_check(`DSW_REG_TIME, 32'h3);
    endtask

    task t_idle();
        ctl.junk();
        repeat (10) @(posedge clk);
        check(64'(got_d.size()), 64'd0);
        check(64'(dq_oe_b), 64'd1);
    endtask

    // every burst length code, with additive latency once
    task t_modes();
        logic [63:0] dm64;
        logic [13:0] ei;
        for (int k = 0; k < 4; k++) begin
            n_end = 0;
            dm64 = (cfg[k][4] != 0) ? '1 : 64'hffff_ffff;
            ei = {1'(cfg[k][4]), 3'(k + 1), 10'(k * 8)};
            ctl.dat[0] = 64'h8877_6655_4433_2211 + 64'(k);
            ctl.msk[0] = 8'h24 >> k;
            reg_write(`DSW_REG_MODE,
                      32'(cfg[k][0] + cfg[k][2] * 16 + cfg[k][3] * 4096));
            ctl.cmd(3'b011, 3'(k + 1), 14'h0);
            ctl.wr(1, cfg[k][2] + cfg[k][3], (cfg[k][4] != 0) ? 8 : 4,
                   3'(k + 1), 10'(k * 8), 1'(k % 2), 1'(cfg[k][1]));
            repeat (30) @(posedge clk);
            check(64'(got_d.size()), 64'd1);
            check(got_d.pop_front() & dm64, ctl.dat[0] & dm64);
            check(64'(got_m.pop_front()),
                  64'(ctl.msk[0] | ((cfg[k][4] != 0) ? 8'h0 : 8'hf0)));
            check(64'(got_i.pop_front()), 64'(ei));
            check(64'(bank_open[k + 1]), 64'(1 - k % 2));
            check(64'(n_end), 64'd1);
        end
    endtask

    task t_concat();
        n_end = 0;
        ctl.dat[0] = 64'h0706_0504_0302_0100;
        ctl.dat[1] = 64'hf7f6_f5f4_f3f2_f1f0;
        ctl.msk[0] = 8'h00;
        ctl.msk[1] = 8'h81;
        reg_write(`DSW_REG_MODE, `DSW_MODE_RST);
        ctl.cmd(3'b011, 3'h0, 14'h0);
        ctl.wr(2, 5, 8, 3'h0, 10'h40, 1'b0, 1'b1);
        repeat (30) @(posedge clk);
        check(64'(got_d.size()), 64'd2);
        check(got_d.pop_front(), ctl.dat[0]);
        check(got_d.pop_front(), ctl.dat[1]);
        check(64'(got_m[1]), 64'h81);
        check(64'(n_end), 64'd2);
        reg_check(`DSW_REG_LAST, 32'h40);
        got_m.delete();
        got_i.delete();
    endtask

    task t_pre();
        reg_write(`DSW_REG_TIME, 32'hf);
        ctl.cmd(3'b011, 3'h2, 14'h0);
        ctl.cmd(3'b011, 3'h6, 14'h0);
        ctl.cmd(3'b010, 3'h2, 14'h0);
        repeat (10) @(posedge clk);
        check(64'(bank_open), 64'h4b);
        check(64'(bank_pre), 64'h04);
        repeat (6) @(negedge ck);
        ctl.cmd(3'b010, 3'h2, 14'h0);
        repeat (12) @(negedge ck);
        check(64'(bank_pre), 64'h04);
        repeat (6) @(negedge ck);
        check(64'(bank_pre), 64'h00);
        ctl.cmd(3'b010, 3'h1, 14'h400);
        repeat (10) @(posedge clk);
        check(64'(bank_open), 64'h00);
        check(64'(bank_pre), 64'hff);
    endtask

    // reset, then each scenario in turn
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        ce = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_idle();
        t_modes();
        t_concat();
        t_pre();
        test_done();
    end

    // watchdog well beyond the expected run
    initial begin
        #1_000_000;
        bad_count++;
        test_done();
    end
endmodule

`default_nettype wire
